// [serial_defines.svh]
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_BAUD 8'h04
`define OFS_TXBUF 8'h08
`define OFS_RXBUF 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_STATE 8'h18

// field widths and positions
`define CTRL_W 9
`define CTRL_SYNC_RX_GO 8
`define STAT_W 7
`define EV_TX_DONE 0
`define EV_TBUF_EMPTY 1
`define EV_RX_DONE 2
`define EV_ERROR 3
`define EV_PARITY 4
`define EV_FRAMING 5
`define EV_OVERRUN 6
`define IRQ_LINES 4

// reset values
`define CTRL_RESET 9'h000
`define BAUD_RESET 13'h0000
`define MASK_RESET 7'h00

// timing: pclk cycles per tick at reload 0, ticks per async bit,
// ticks per half period of the synchronous shift clock
`define BAUD_RELOAD_W 13
`define PRESCALE 2
`define ASYNC_TICKS 16
`define ASYNC_MID_TICK 7
`define SYNC_HALF_TICKS 2

`endif

// [serial_pkg.sv]
package serial_pkg;

  typedef struct packed {
    logic sync_rx_go;
    logic loopback;
    logic wake;
    logic odd;
    logic parity;
    logic two_stop;
    logic nine;
    logic sync_mode;
    logic enable;
  } ctrl_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_answer_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_ASYNC = 2'b01,
    E_SYNC_LO = 2'b10,
    E_SYNC_HI = 2'b11
  } engine_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_START = 2'b01,
    R_DATA = 2'b10
  } rx_state_t;

endpackage : serial_pkg

// [baud_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.svh"

module baud_tick_gen #(
  parameter int RELOAD_W = `BAUD_RELOAD_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [RELOAD_W-1:0] reload,
  output logic tick
);
  initial if (RELOAD_W < 1 || RELOAD_W > 16) $error("baud_tick_gen: RELOAD_W out of range");

  logic [RELOAD_W-1:0] count_reg;
  logic pre_reg;

  // fixed divide by two keeps the top async rate at pclk/32
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_reg <= 1'b0;
      count_reg <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      pre_reg <= 1'b0;
      count_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      pre_reg <= ~pre_reg;
      tick <= 1'b0;
      if (pre_reg)
      begin
        if (count_reg == '0)
        begin
          count_reg <= reload;
          tick <= 1'b1;
        end
        else
          count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : baud_tick_gen
`default_nettype wire

// [pin_sync3.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // idle line is high; a change counts only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level <= s3_reg;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// [serial_channel_zero.sv]
// What this block does
// - async mode sends and receives at once, up to pclk/32 bit rate
// - sync mode is half duplex, shifting up to pclk/8
// - own reloadable baud generator divides the clock
// - four interrupt requests: transmit, transmit buffer, receive, error
// - async frame: start, 8 or 9 data bits, one or two stop bits
// - wake-up mode sends 8 data bits plus an address/data bit
// - sync transfer is one byte against a self-made shift clock
// - least significant bit always goes first
// - loop-back setting feeds the sent stream to the receiver
// - transmit pin carries data when async, shift clock when sync
// - receive pin is input when async, two-way data line when sync
// - parity generated on send and checked on receive when enabled and wake-up is off
// - missing stop bit raises a framing error
// - new character while the old one is unread raises overrun
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.svh"

module serial_channel_zero
  import serial_pkg::*;
#(
  parameter int RELOAD_W = `BAUD_RELOAD_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serial_transmit_pin,
  input wire logic serial_receive_pin_in,
  output logic serial_receive_pin_out,
  output logic serial_receive_pin_oe,
  output logic [`IRQ_LINES-1:0] irq_line,
  output logic irq
);
  import serial_pkg::*;

  initial if (RELOAD_W < 1 || RELOAD_W > 16) $error("serial_channel_zero: RELOAD_W out of range");

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `OFS_CTRL || a == `OFS_BAUD || a == `OFS_TXBUF || a == `OFS_RXBUF ||
           a == `OFS_STATUS || a == `OFS_MASK || a == `OFS_STATE;
  endfunction : is_mapped

  ctrl_t ctrl_reg;
  logic [RELOAD_W-1:0] baud_reg;
  logic [`STAT_W-1:0] status_reg;
  logic [`STAT_W-1:0] mask_reg;
  logic [8:0] txbuf_reg;
  logic tx_full_reg;
  logic [8:0] rxbuf_reg;
  logic rx_full_reg;
  apb_answer_t ans_reg;

  engine_state_t eng_reg;
  logic [11:0] sh_reg;
  logic [3:0] bits_left_reg;
  logic [3:0] etick_reg;
  logic sync_dir_rx_reg;
  logic [7:0] sync_rsh_reg;
  logic line_reg;
  logic dout_reg;
  logic doe_reg;

  rx_state_t rx_reg;
  logic [3:0] rtick_reg;
  logic [3:0] rcount_reg;
  logic [9:0] rbits_reg;

  logic tick;
  logic pin_level;
  logic rx_in;
  logic use9;
  logic tx_ninth;
  logic [3:0] frame_len;
  logic wr_acc;
  logic rd_acc;
  logic load_async;
  logic load_sync;
  logic ev_tx_done;
  logic ev_sync_rx;
  logic ev_rx_async;
  logic stop_ok;
  logic par_bad;
  logic [`STAT_W-1:0] events;
  logic [`STAT_W-1:0] status_next;

  baud_tick_gen #(
    .RELOAD_W(RELOAD_W)
  ) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_reg.enable),
    .reload(baud_reg),
    .tick(tick)
  );

  pin_sync3 u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(serial_receive_pin_in),
    .level(pin_level)
  );

  // apb: answer registered in the setup cycle, so every access has no wait
  assign wr_acc = psel && penable && ans_reg.pready && pwrite;
  assign rd_acc = psel && penable && ans_reg.pready && !pwrite;
  assign prdata = ans_reg.prdata;
  assign pready = ans_reg.pready;
  assign pslverr = ans_reg.pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ans_reg <= '0;
    else
    begin
      ans_reg.pready <= psel && !penable;
      ans_reg.pslverr <= psel && !penable && !is_mapped(paddr);
      ans_reg.prdata <= '0;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          `OFS_CTRL: ans_reg.prdata <= {23'h000000, ctrl_reg};
          `OFS_BAUD: ans_reg.prdata <= 32'(baud_reg);
          `OFS_RXBUF: ans_reg.prdata <= {23'h000000, rxbuf_reg};
          `OFS_STATUS: ans_reg.prdata <= {25'h0000000, status_reg};
          `OFS_MASK: ans_reg.prdata <= {25'h0000000, mask_reg};
          `OFS_STATE: ans_reg.prdata <= {26'h0000000, rx_reg, eng_reg, rx_full_reg, tx_full_reg};
          default: ans_reg.prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `CTRL_RESET;
      baud_reg <= RELOAD_W'(`BAUD_RESET);
      mask_reg <= `MASK_RESET;
    end
    else
    begin
      if (wr_acc && paddr == `OFS_CTRL)
        ctrl_reg <= ctrl_t'(pwdata[`CTRL_W-1:0]);
      else if (load_sync)
        ctrl_reg.sync_rx_go <= 1'b0;
      if (wr_acc && paddr == `OFS_BAUD)
        baud_reg <= pwdata[RELOAD_W-1:0];
      if (wr_acc && paddr == `OFS_MASK)
        mask_reg <= pwdata[`STAT_W-1:0];
    end
  end

  // transmit buffer: software fills it, the engine empties it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txbuf_reg <= '0;
      tx_full_reg <= 1'b0;
    end
    else if (wr_acc && paddr == `OFS_TXBUF)
    begin
      txbuf_reg <= pwdata[8:0];
      tx_full_reg <= 1'b1;
    end
    else if ((load_async || load_sync) && !sync_go_rx())
      tx_full_reg <= 1'b0;
  end

  function automatic logic sync_go_rx();
    return ctrl_reg.sync_rx_go;
  endfunction : sync_go_rx

  // ninth bit slot used for data, parity or wake-up bit
  assign use9 = ctrl_reg.nine || ctrl_reg.parity || ctrl_reg.wake;
  // wake-up bit taken from bit 8 of the buffer
  // even or odd parity over the eight data bits
  assign tx_ninth = ctrl_reg.wake ? txbuf_reg[8] :
                    ctrl_reg.parity ? (^txbuf_reg[7:0]) ^ ctrl_reg.odd : txbuf_reg[8];
  assign frame_len = 4'd10 + {3'b000, use9} + {3'b000, ctrl_reg.two_stop};

  assign load_async = eng_reg == E_IDLE && ctrl_reg.enable && !ctrl_reg.sync_mode && tx_full_reg;
  // half duplex: a sync receive waits for the shared engine
  assign load_sync = eng_reg == E_IDLE && ctrl_reg.enable && ctrl_reg.sync_mode &&
                     (ctrl_reg.sync_rx_go || tx_full_reg);

  assign ev_tx_done = tick && etick_reg == 4'(`SYNC_HALF_TICKS - 1) && eng_reg == E_SYNC_HI &&
                      bits_left_reg == 4'd1 && !sync_dir_rx_reg ||
                      tick && etick_reg == 4'(`ASYNC_TICKS - 1) && eng_reg == E_ASYNC &&
                      bits_left_reg == 4'd1;
  assign ev_sync_rx = tick && etick_reg == 4'(`SYNC_HALF_TICKS - 1) && eng_reg == E_SYNC_HI &&
                      bits_left_reg == 4'd1 && sync_dir_rx_reg;

  // transmit and synchronous engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eng_reg <= E_IDLE;
      sh_reg <= '1;
      bits_left_reg <= '0;
      etick_reg <= '0;
      sync_dir_rx_reg <= 1'b0;
      sync_rsh_reg <= '0;
      line_reg <= 1'b1;
      dout_reg <= 1'b1;
      doe_reg <= 1'b0;
    end
    else if (!ctrl_reg.enable)
    begin
      eng_reg <= E_IDLE;
      line_reg <= 1'b1;
      doe_reg <= 1'b0;
      etick_reg <= '0;
    end
    else
    begin
      unique case (eng_reg)
        E_IDLE:
        begin
          etick_reg <= '0;
          if (load_async)
          begin
            // start, data lsb first, ninth, stop bits
            sh_reg <= {2'b11, use9 ? tx_ninth : 1'b1, txbuf_reg[7:0], 1'b0};
            bits_left_reg <= frame_len;
            line_reg <= 1'b0;
            eng_reg <= E_ASYNC;
          end
          else if (load_sync)
          begin
            // one byte, the channel drives the shift clock low first
            sync_dir_rx_reg <= ctrl_reg.sync_rx_go;
            sh_reg <= {4'hf, txbuf_reg[7:0]};
            bits_left_reg <= 4'd8;
            line_reg <= 1'b0;
            dout_reg <= ctrl_reg.sync_rx_go ? 1'b1 : txbuf_reg[0];
            doe_reg <= !ctrl_reg.sync_rx_go;
            eng_reg <= E_SYNC_LO;
          end
        end
        E_ASYNC:
        begin
          if (tick)
          begin
            etick_reg <= etick_reg + 4'd1;
            if (etick_reg == 4'(`ASYNC_TICKS - 1))
            begin
              // shifting right sends bit 0 first
              sh_reg <= {1'b1, sh_reg[11:1]};
              bits_left_reg <= bits_left_reg - 4'd1;
              // async data on the transmit pin
              line_reg <= sh_reg[1];
              if (bits_left_reg == 4'd1)
                eng_reg <= E_IDLE;
            end
          end
        end
        E_SYNC_LO:
        begin
          if (tick)
          begin
            etick_reg <= etick_reg + 4'd1;
            if (etick_reg == 4'(`SYNC_HALF_TICKS - 1))
            begin
              etick_reg <= '0;
              // shift clock on the transmit pin
              line_reg <= 1'b1;
              eng_reg <= E_SYNC_HI;
            end
          end
        end
        E_SYNC_HI:
        begin
          if (tick)
          begin
            etick_reg <= etick_reg + 4'd1;
            if (etick_reg == 4'(`SYNC_HALF_TICKS - 1))
            begin
              etick_reg <= '0;
              // sampled late in the high phase to absorb the pin synchroniser
              // received bits fill from the top, first bit ends in bit 0
              sync_rsh_reg <= {rx_in, sync_rsh_reg[7:1]};
              sh_reg <= {1'b1, sh_reg[11:1]};
              bits_left_reg <= bits_left_reg - 4'd1;
              if (bits_left_reg == 4'd1)
              begin
                eng_reg <= E_IDLE;
                doe_reg <= 1'b0;
                dout_reg <= 1'b1;
              end
              else
              begin
                line_reg <= 1'b0;
                // drive the data line only when sending
                if (!sync_dir_rx_reg)
                  dout_reg <= sh_reg[1];
                eng_reg <= E_SYNC_LO;
              end
            end
          end
        end
      endcase
    end
  end

  assign serial_transmit_pin = line_reg;
  assign serial_receive_pin_out = dout_reg;
  assign serial_receive_pin_oe = doe_reg;

  // loop-back takes the internal stream instead of the pin
  assign rx_in = !ctrl_reg.loopback ? pin_level : ctrl_reg.sync_mode ? dout_reg : line_reg;

  // stop bit sampled in the slot after the last data bit
  assign stop_ok = rx_in;
  // parity check over data and received parity bit
  assign par_bad = ctrl_reg.parity && !ctrl_reg.wake && ((^rbits_reg[8:0]) ^ ctrl_reg.odd);
  // receiver runs independently of the transmit engine
  assign ev_rx_async = rx_reg == R_DATA && tick && rtick_reg == 4'(`ASYNC_TICKS - 1) &&
                       rcount_reg == (use9 ? 4'd9 : 4'd8);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_reg <= R_IDLE;
      rtick_reg <= '0;
      rcount_reg <= '0;
      rbits_reg <= '0;
    end
    else if (!ctrl_reg.enable || ctrl_reg.sync_mode)
      rx_reg <= R_IDLE;
    else
    begin
      unique case (rx_reg)
        R_IDLE:
        begin
          rtick_reg <= '0;
          rcount_reg <= '0;
          if (!rx_in)
            rx_reg <= R_START;
        end
        R_START:
        begin
          if (tick)
          begin
            rtick_reg <= rtick_reg + 4'd1;
            // a start bit shorter than half a bit is a glitch
            if (rtick_reg == 4'(`ASYNC_MID_TICK))
            begin
              rtick_reg <= '0;
              rx_reg <= rx_in ? R_IDLE : R_DATA;
            end
          end
        end
        R_DATA:
        begin
          if (tick)
          begin
            rtick_reg <= rtick_reg + 4'd1;
            if (rtick_reg == 4'(`ASYNC_TICKS - 1))
            begin
              rbits_reg[rcount_reg] <= rx_in;
              rcount_reg <= rcount_reg + 4'd1;
              if (ev_rx_async)
                rx_reg <= R_IDLE;
            end
          end
        end
        default: rx_reg <= R_IDLE;
      endcase
    end
  end

  // receive buffer: a new character sets full even in the cycle it is read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxbuf_reg <= '0;
      rx_full_reg <= 1'b0;
    end
    else if (ev_rx_async || ev_sync_rx)
    begin
      rxbuf_reg <= ev_sync_rx ? {1'b0, rx_in, sync_rsh_reg[7:1]} :
                   {use9 ? rbits_reg[8] : 1'b0, rbits_reg[7:0]};
      rx_full_reg <= 1'b1;
    end
    else if (rd_acc && paddr == `OFS_RXBUF)
      rx_full_reg <= 1'b0;
  end

  always_comb
  begin
    events = '0;
    events[`EV_TX_DONE] = ev_tx_done;
    events[`EV_TBUF_EMPTY] = (load_async || load_sync) && !ctrl_reg.sync_rx_go;
    events[`EV_RX_DONE] = ev_rx_async || ev_sync_rx;
    events[`EV_FRAMING] = ev_rx_async && !stop_ok;
    events[`EV_PARITY] = ev_rx_async && par_bad;
    // overrun when the previous character is still unread
    events[`EV_OVERRUN] = (ev_rx_async || ev_sync_rx) && rx_full_reg;
    events[`EV_ERROR] = events[`EV_FRAMING] || events[`EV_PARITY] || events[`EV_OVERRUN];
    status_next = status_reg;
    if (wr_acc && paddr == `OFS_STATUS)
      status_next = status_reg & ~pwdata[`STAT_W-1:0];
    status_next = status_next | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  // one request line per event group, registered
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_LINES; gi++)
    begin : g_irq
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_line[gi] <= 1'b0;
        else
          irq_line[gi] <= status_next[gi] && mask_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end
endmodule : serial_channel_zero
`default_nettype wire

// [channel_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.svh"

module channel_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_transmit_pin,
  input wire logic serial_receive_pin_out,
  input wire logic serial_receive_pin_oe,
  input wire logic [`IRQ_LINES-1:0] irq_line,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_one_access;
    pready ##1 !pready;
  endsequence

  AST_READY_NEXT: assert property (s_setup |=> s_one_access) else $error("pready not one cycle after setup");
  AST_READY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable)) else $error("pready without setup");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0) else $error("no slverr");
  AST_MAPPED: assert property (psel && !penable && paddr <= 8'h18 && paddr[1:0] == 2'b00 |=> !pslverr) else $error("slverr");
  AST_IRQ_SUM: assert property (irq_line != '0 |-> irq) else $error("irq low with a line high");
  AST_RESET_IDLE: assert property ($rose(presetn) |-> serial_transmit_pin && !irq && irq_line == '0 && !serial_receive_pin_oe) else $error("not idle");
  AST_LOW_MIN: assert property ($fell(serial_transmit_pin) |-> !serial_transmit_pin [*3]) else $error("low phase too short");
  AST_DRIVE_LOW: assert property ($rose(serial_receive_pin_oe) |-> ##[0:1] !serial_transmit_pin) else $error("drive outside low phase");
  AST_DATA_HELD: assert property (serial_receive_pin_oe && $rose(serial_transmit_pin) |=> $stable(serial_receive_pin_out) [*3]) else $error("data moved");
endmodule : channel_checker

bind serial_channel_zero channel_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_transmit_pin(serial_transmit_pin),
  .serial_receive_pin_out(serial_receive_pin_out), .serial_receive_pin_oe(serial_receive_pin_oe),
  .irq_line(irq_line), .irq(irq));
`default_nettype wire

// [remote_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module remote_peer (
  input wire logic pclk,
  input wire logic tx_pin,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic line
);
  logic drive_en = 1'b1;
  logic drive_val = 1'b1;
  logic last = 1'b1;

  // shared data line
  // released line toggles so a stale value is never mistaken for data
  assign line = dev_oe ? dev_out : (drive_en ? drive_val : ~last);
  always @(posedge pclk) last <= line;

  task automatic send_async(input logic [8:0] d, input int n, input logic stop);
    for (int i = -1; i <= n; i++)
    begin
      @(posedge pclk);
      drive_val <= (i < 0) ? 1'b0 : (i == n) ? stop : d[i];
      repeat (31) @(posedge pclk);
    end
    @(posedge pclk);
    drive_val <= 1'b1;
    repeat (31) @(posedge pclk);
  endtask : send_async

  task automatic recv_async(input int n, output logic [8:0] d);
    d = 9'h000;
    @(negedge pclk);
    while (tx_pin) @(negedge pclk);
    repeat (16) @(negedge pclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (32) @(negedge pclk);
      d[i] = tx_pin;
    end
  endtask : recv_async

  // change after fall, hold through high
  task automatic sync_io(input logic [7:0] d, output logic [7:0] got);
    int i;
    logic prev;
    i = 0;
    prev = 1'b1;
    got = 8'h00;
    @(posedge pclk);
    drive_en <= 1'b1;
    drive_val <= d[0];
    while (i < 8)
    begin
      @(negedge pclk);
      if (!prev && tx_pin)
      begin
        got[i] = line;
        i++;
      end
      else if (prev && !tx_pin && i > 0)
      begin
        @(posedge pclk);
        drive_val <= d[i];
      end
      prev = tx_pin;
    end
    repeat (6) @(posedge pclk);
    drive_en <= 1'b0;
  endtask : sync_io
endmodule : remote_peer
`default_nettype wire

// [serial_channel_zero_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.svh"

module serial_channel_zero_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, txp, rxi, rxo, rxoe, irq;
  logic [`IRQ_LINES-1:0] irq_line;
  logic [8:0] d, got;
  logic [7:0] b, e, c;
  logic [8:0] q[$];
  logic [7:0] modes[6] = '{8'h81, 8'h85, 8'h99, 8'hb1, 8'hc1, 8'hd1};
  int failures = 0;
  int n_compared = 0;
  int seed = 15;
  int cycles = 0;

  serial_channel_zero DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_transmit_pin(txp), .serial_receive_pin_in(rxi), .serial_receive_pin_out(rxo),
    .serial_receive_pin_oe(rxoe), .irq_line(irq_line), .irq(irq));
  remote_peer peer (.pclk(pclk), .tx_pin(txp), .dev_out(rxo), .dev_oe(rxoe), .line(rxi));

  always #50 pclk = ~pclk;

  task automatic complete_run();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // full run is about 4300 cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic cmp_val(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      failures++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask : cmp_val

  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    cmp_val($sformatf("reg %h", a), x, rd);
    cmp_val($sformatf("slverr %h", a), 32'(xe), 32'(err));
  endtask : cmp_reg

  task automatic wait_bit(input int n);
    rd = 32'h0;
    for (int k = 0; k < 500 && rd[n] !== 1'b1; k++) apb(1'b0, `OFS_STATUS, 32'h0);
    // a wait that runs out is a mismatch, not a silent pass
    if (rd[n] !== 1'b1)
    begin
      failures++;
      $display("Error status bit %0d expected 1 seen %b", n, rd[n]);
    end
  endtask : wait_bit

  task automatic drain();
    apb(1'b0, `OFS_RXBUF, 32'h0);
    apb(1'b1, `OFS_STATUS, 32'h7f);
  endtask : drain

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_val("tx idle", 32'h1, 32'(txp));
    apb(1'b1, `OFS_STATE, 32'hffffffff);
    for (int a = 0; a <= 24; a += 4) if (a != 12) cmp_reg(8'(a), 32'h0, 1'b0);
    cmp_reg(8'h1c, 32'h0, 1'b1);
    $display("test reset done");
    apb(1'b1, `OFS_MASK, 32'h7f);
    apb(1'b1, `OFS_CTRL, 32'h1);
    d = 9'($random(seed)) & 9'h0ff;
    q.push_back(~d & 9'h0ff);
    fork
      peer.recv_async(8, got);
      apb(1'b1, `OFS_TXBUF, 32'(d));
      peer.send_async(q[0], 8, 1'b1);
    join
    cmp_val("peer rx", 32'(d), 32'(got));
    wait_bit(`EV_TX_DONE);
    cmp_reg(`OFS_STATUS, 32'h7, 1'b0);
    cmp_val("irq", 32'h0f, 32'({irq_line, irq}));
    cmp_reg(`OFS_RXBUF, 32'(q.pop_front()), 1'b0);
    apb(1'b1, `OFS_STATUS, 32'h7f);
    cmp_val("irq clear", 32'h0, 32'({irq_line, irq}));
    $display("test duplex done");
    foreach (modes[m])
    begin
      c = modes[m];
      apb(1'b1, `OFS_CTRL, 32'(c));
      d = 9'($random(seed));
      q.push_back({(c[2] | c[4] | c[6]) & (c[6] ? d[8] : c[4] ? (^d[7:0]) ^ c[5] : d[8]), d[7:0]});
      apb(1'b1, `OFS_TXBUF, 32'(d));
      wait_bit(`EV_TX_DONE);
      cmp_reg(`OFS_STATUS, 32'h7, 1'b0);
      cmp_reg(`OFS_RXBUF, 32'(q.pop_front()), 1'b0);
      apb(1'b1, `OFS_STATUS, 32'h7f);
    end
    $display("test loopback done");
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_MASK, 32'h8);
    peer.send_async(9'h05a, 8, 1'b0);
    wait_bit(`EV_ERROR);
    cmp_val("framing", 32'h28, rd & 32'h78);
    cmp_val("masked irq", 32'h11, 32'({irq_line, irq}));
    drain();
    repeat (2) peer.send_async(9'h033, 8, 1'b1);
    wait_bit(`EV_ERROR);
    cmp_val("overrun", 32'h48, rd & 32'h78);
    drain();
    apb(1'b1, `OFS_CTRL, 32'h11);
    peer.send_async(9'h001, 9, 1'b1);
    wait_bit(`EV_ERROR);
    cmp_val("parity", 32'h18, rd & 32'h78);
    drain();
    $display("test errors done");
    apb(1'b1, `OFS_CTRL, 32'h3);
    c = 8'($random(seed));
    e = 8'($random(seed));
    fork
      peer.sync_io(8'h00, b);
      apb(1'b1, `OFS_TXBUF, 32'(c));
    join
    cmp_val("sync tx", 32'(c), 32'(b));
    wait_bit(`EV_TX_DONE);
    fork
      peer.sync_io(e, b);
      apb(1'b1, `OFS_CTRL, 32'h103);
    join
    wait_bit(`EV_RX_DONE);
    cmp_reg(`OFS_RXBUF, 32'(e), 1'b0);
    $display("test sync done");
    complete_run();
  end
endmodule : serial_channel_zero_bench
`default_nettype wire
